// ---- include/apc_pkg.sv ----
// Package for the alarm point configuration and compare block
`default_nettype none
package apc_pkg;
  // APB register byte offsets
  localparam logic [7:0] APC_CFG_OFF = 8'h00;
  localparam logic [7:0] APC_FNC_OFF = 8'h04;
  localparam logic [7:0] APC_CNT_OFF = 8'h08;
  localparam logic [7:0] APC_SPHY_OFF = 8'h0C;
  localparam logic [7:0] APC_ALHY_OFF = 8'h10;
  localparam logic [7:0] APC_PT1_OFF = 8'h14;
  localparam logic [7:0] APC_PT2_OFF = 8'h18;
  localparam logic [7:0] APC_STAT_OFF = 8'h1C;
  localparam logic [7:0] APC_REF1_OFF = 8'h20;
  localparam logic [7:0] APC_REF2_OFF = 8'h24;
  // Configuration bit positions of the alarm configuration page
  localparam int APC_B_ZONE1 = 0;
  localparam int APC_B_POL1 = 1;
  localparam int APC_B_SRC1 = 2;
  localparam int APC_B_ZONE2 = 3;
  localparam int APC_B_POL2 = 4;
  localparam int APC_B_SRC2 = 5;
  localparam int APC_B_DIS = 6;
  localparam int APC_B_EXTEN = 7;
  // Factory presets
  localparam logic [7:0] APC_CFG_RST = 8'h00;
  localparam logic [7:0] APC_FNC_RST = 8'h00;
  localparam logic [3:0] APC_CNT_RST = 4'h3;
  localparam logic [3:0] APC_CNT_MIN = 4'h1;
  localparam logic [3:0] APC_CNT_MAX = 4'hF;
  localparam logic [15:0] APC_HYS_RST = 16'h0020;
  localparam logic [3:0] APC_DIGIT_MAX = 4'h9;
  // Alarm modes
  localparam logic [1:0] APC_M_PROC = 2'h0;
  localparam logic [1:0] APC_M_HDEV = 2'h1;
  localparam logic [1:0] APC_M_LDEV = 2'h2;
  localparam logic [1:0] APC_M_BAND = 2'h3;
  localparam int APC_RW = 16;
  typedef enum logic [2:0] {
    APC_PG_CFG, APC_PG_FNC, APC_PG_CNT, APC_PG_SPHY, APC_PG_ALHY,
    APC_PG_OUT
  } apc_page_t;
  // Per-alarm settings as one carrier
  typedef struct packed {
    logic zone_below;
    logic pol_off;
    logic src_filt;
    logic [1:0] mode;
    logic latch;
    logic [3:0] count;
    logic [15:0] point;
    logic [15:0] ref_val;
    logic [15:0] hys;
    logic disable_all;
    logic ext_en;
  } apc_alarm_cfg_t;
  // Button pulses
  typedef struct packed {
    logic menu;
    logic min;
    logic max;
  } apc_keys_t;
endpackage : apc_pkg
`default_nettype wire

// ---- logic/apc_sync.sv ----
// Two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module apc_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q,
  output logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } apc_sync_st_t;
  apc_sync_st_t st_r, st_nxt;
  // Shift chain; s1 only feeds s2
  always_comb begin
    st_nxt = '{s1: d, s2: st_r.s1, s3: st_r.s2};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.s2;
  assign rise = st_r.s2 & ~st_r.s3;
endmodule // apc_sync
`default_nettype wire

// ---- logic/apc_alarm.sv ----
// One alarm comparator with hysteresis, qualification and latch
`timescale 1ns/1ps
`default_nettype none
module apc_alarm
  import apc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire apc_pkg::apc_alarm_cfg_t cfg,
  input wire logic [15:0] rdg_raw,
  input wire logic [15:0] rdg_filt,
  input wire logic rdg_valid,
  input wire logic ext_reset,
  output logic active
);
  typedef struct packed {
    logic act;
    logic [3:0] qual;
  } apc_al_st_t;
  apc_al_st_t st_r, st_nxt;
  logic signed [17:0] rdg, lo, hi, half, dev;
  logic trip, clear;
  always_comb begin
    st_nxt = st_r;
    rdg = cfg.src_filt ? {2'b00, rdg_filt} : {2'b00, rdg_raw}; // R3
    half = {3'b000, cfg.hys[15:1]};
    lo = {2'b00, cfg.point};
    hi = {2'b00, cfg.point};
    dev = rdg - {2'b00, cfg.ref_val};
    trip = 1'b0;
    clear = 1'b0;
    // Mode picks threshold; process splits the deadband evenly
    case (cfg.mode)
      APC_M_PROC: begin
        hi = lo + half; // R7
        lo = lo - half; // R7
      end
      APC_M_HDEV: begin
        rdg = dev;
        hi = lo;
        lo = lo - {2'b00, cfg.hys};
      end
      APC_M_LDEV: begin
        rdg = -dev;
        hi = lo;
        lo = lo - {2'b00, cfg.hys};
      end
      APC_M_BAND: begin
        rdg = (dev < 0) ? -dev : dev;
        hi = lo;
        lo = lo - {2'b00, cfg.hys};
      end
      default: begin
        hi = lo;
      end
    endcase
    // Zone bit flips the sense of the compare
    if (!cfg.zone_below) begin // R1
      trip = rdg > hi;
      clear = rdg <= lo;
    end else begin
      trip = rdg < lo;
      clear = rdg >= hi;
    end
    if (rdg_valid) begin
      if (trip && !st_r.act) begin
        // Counter restarts on any non-qualifying reading
        if (st_r.qual + 4'h1 >= cfg.count) begin // R9
          st_nxt.act = 1'b1;
          st_nxt.qual = '0;
        end else begin
          st_nxt.qual = st_r.qual + 4'h1;
        end
      end else if (!trip) begin
        st_nxt.qual = '0; // R17
      end
      if (clear && !cfg.latch) begin // R8
        st_nxt.act = 1'b0;
      end
    end
    // Latched alarm falls only to an honoured external reset or the common disable
    if (cfg.latch && ext_reset && cfg.ext_en) begin // R17 R5
      st_nxt.act = 1'b0;
      st_nxt.qual = '0;
    end
    if (cfg.disable_all) begin // R4
      st_nxt = '0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign active = st_r.act;
endmodule // apc_alarm
`default_nettype wire

// ---- logic/apc_top.sv ----
// Alarm point configuration store, keypad editor and two comparators
// How it works
// R1 - Zone bit 0 alarms above the point, 1 alarms below it.
// R2 - Polarity bit 0 drives the output on while active, 1 drives it off.
// R3 - Source bit 0 compares the unfiltered reading, 1 the filtered one.
// R4 - Common disable bit 1 silences both alarms and their LEDs.
// R5 - Reset-input enable 1 honours the external alarm reset, 0 ignores it.
// R6 - Two-bit mode: process, high, low or band deviation; preset process.
// R7 - Process mode spreads the deadband equally around the point.
// R8 - Latch bit 0 self-clears the alarm, 1 holds it once tripped.
// R9 - Each alarm needs 1 to 15 consecutive qualifying readings, preset 3.
// R10 - The setpoint deadband is four decimal digits, preset 0020.
// R11 - The alarm deadband is four decimal digits, preset 0020.
// R12 - On the configuration page MIN steps eight items, MAX toggles one.
// R13 - MENU commits the page and advances through the six pages in order.
// R14 - On the count page MIN moves pairs and MAX steps a count in 1..15.
// R15 - On a deadband page MIN shows then picks digits, MAX bumps a digit.
// R16 - Factory presets load at reset, zone above and process mode.
// R17 - Latched alarms clear on honoured external reset; counts restart.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module apc_top
  import apc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic key_menu,
  input wire logic key_min,
  input wire logic key_max,
  input wire logic ext_alarm_reset,
  input wire logic [15:0] rdg_raw,
  input wire logic [15:0] rdg_filt,
  input wire logic rdg_valid,
  output logic alarm1_out,
  output logic alarm2_out,
  output logic alarm1_led,
  output logic alarm2_led,
  output logic [2:0] page,
  output logic [2:0] cursor
);
  import apc_pkg::*;
  // Whole state: committed config, edit copies and pins
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] fnc;
    logic [3:0] cnt1;
    logic [3:0] cnt2;
    logic [15:0] sphy;
    logic [15:0] alhy;
    logic [15:0] pt1;
    logic [15:0] pt2;
    logic [15:0] ref1;
    logic [15:0] ref2;
    logic [7:0] e_cfg;
    logic [7:0] e_fnc;
    logic [3:0] e_cnt1;
    logic [3:0] e_cnt2;
    logic [15:0] e_hys;
    apc_page_t pg;
    logic [2:0] cur;
    logic shown;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic a1o;
    logic a2o;
    logic a1l;
    logic a2l;
  } apc_top_st_t;
  apc_top_st_t st_r, st_nxt;
  apc_keys_t keys;
  apc_alarm_cfg_t c1, c2;
  logic act1, act2, ext_q, ext_unused;
  logic [3:0] dg;

  // Buttons and reset pin come from outside; synchronise all, edge-detect only the buttons
  apc_sync u_menu (.pclk(pclk), .presetn(presetn), .d(key_menu),
    .q(), .rise(keys.menu));
  apc_sync u_min (.pclk(pclk), .presetn(presetn), .d(key_min),
    .q(), .rise(keys.min));
  apc_sync u_max (.pclk(pclk), .presetn(presetn), .d(key_max),
    .q(), .rise(keys.max));
  apc_sync u_ext (.pclk(pclk), .presetn(presetn), .d(ext_alarm_reset),
    .q(ext_q), .rise(ext_unused));

  // Committed settings per alarm
  always_comb begin
    c1 = '{zone_below: st_r.cfg[APC_B_ZONE1], pol_off: st_r.cfg[APC_B_POL1],
      src_filt: st_r.cfg[APC_B_SRC1], mode: st_r.fnc[1:0],
      latch: st_r.fnc[2], count: st_r.cnt1, point: st_r.pt1,
      ref_val: st_r.ref1, hys: st_r.alhy,
      disable_all: st_r.cfg[APC_B_DIS], ext_en: st_r.cfg[APC_B_EXTEN]};
    c2 = '{zone_below: st_r.cfg[APC_B_ZONE2], pol_off: st_r.cfg[APC_B_POL2],
      src_filt: st_r.cfg[APC_B_SRC2], mode: st_r.fnc[4:3],
      latch: st_r.fnc[5], count: st_r.cnt2, point: st_r.pt2,
      ref_val: st_r.ref2, hys: st_r.alhy,
      disable_all: st_r.cfg[APC_B_DIS], ext_en: st_r.cfg[APC_B_EXTEN]};
  end

  apc_alarm u_al1 (.pclk(pclk), .presetn(presetn), .cfg(c1),
    .rdg_raw(rdg_raw), .rdg_filt(rdg_filt), .rdg_valid(rdg_valid),
    .ext_reset(ext_q), .active(act1));
  apc_alarm u_al2 (.pclk(pclk), .presetn(presetn), .cfg(c2),
    .rdg_raw(rdg_raw), .rdg_filt(rdg_filt), .rdg_valid(rdg_valid),
    .ext_reset(ext_q), .active(act2));

  // Keypad editor, APB slave and output registers
  always_comb begin
    st_nxt = st_r;
    dg = 4'h0;
    st_nxt.rdy = 1'b0;
    st_nxt.err = 1'b0;
    // Outputs: polarity and common disable, registered to the pins
    st_nxt.a1o = ~st_r.cfg[APC_B_DIS] & (act1 ^ st_r.cfg[APC_B_POL1]); // R2 R4
    st_nxt.a2o = ~st_r.cfg[APC_B_DIS] & (act2 ^ st_r.cfg[APC_B_POL2]); // R2 R4
    st_nxt.a1l = ~st_r.cfg[APC_B_DIS] & act1; // R4
    st_nxt.a2l = ~st_r.cfg[APC_B_DIS] & act2; // R4
    if (keys.menu) begin
      // Commit the page being edited, then load the next page's copy
      case (st_r.pg)
        APC_PG_CFG: st_nxt.cfg = st_r.e_cfg; // R13
        APC_PG_FNC: st_nxt.fnc = st_r.e_fnc; // R13
        APC_PG_CNT: begin
          st_nxt.cnt1 = st_r.e_cnt1; // R13
          st_nxt.cnt2 = st_r.e_cnt2;
        end
        APC_PG_SPHY: st_nxt.sphy = st_r.e_hys; // R13 R10
        APC_PG_ALHY: st_nxt.alhy = st_r.e_hys; // R13 R11
        default: st_nxt.cfg = st_r.cfg;
      endcase
      st_nxt.cur = '0;
      st_nxt.shown = 1'b0;
      st_nxt.e_cfg = st_nxt.cfg;
      st_nxt.e_fnc = st_nxt.fnc;
      st_nxt.e_cnt1 = st_nxt.cnt1;
      st_nxt.e_cnt2 = st_nxt.cnt2;
      case (st_r.pg)
        APC_PG_CFG: st_nxt.pg = APC_PG_FNC; // R13
        APC_PG_FNC: st_nxt.pg = APC_PG_CNT;
        APC_PG_CNT: begin
          st_nxt.pg = APC_PG_SPHY;
          st_nxt.e_hys = st_r.sphy;
        end
        APC_PG_SPHY: begin
          st_nxt.pg = APC_PG_ALHY;
          st_nxt.e_hys = st_r.alhy;
        end
        APC_PG_ALHY: st_nxt.pg = APC_PG_OUT;
        default: st_nxt.pg = APC_PG_CFG;
      endcase
    end else if (keys.min) begin
      case (st_r.pg)
        APC_PG_CFG: st_nxt.cur = st_r.cur + 3'h1; // R12
        APC_PG_FNC: st_nxt.cur = {1'b0, st_r.cur[1:0] + 2'h1};
        APC_PG_CNT: st_nxt.cur = {2'b00, ~st_r.cur[0]}; // R14
        APC_PG_SPHY, APC_PG_ALHY: begin
          // First press only shows the value
          if (!st_r.shown) begin // R15
            st_nxt.shown = 1'b1;
          end else begin
            st_nxt.cur = {1'b0, st_r.cur[1:0] + 2'h1}; // R15
          end
        end
        default: st_nxt.cur = '0;
      endcase
    end else if (keys.max) begin
      case (st_r.pg)
        APC_PG_CFG: st_nxt.e_cfg[st_r.cur] = ~st_r.e_cfg[st_r.cur]; // R12
        APC_PG_FNC: begin
          case (st_r.cur[1:0])
            2'h0: st_nxt.e_fnc[1:0] = st_r.e_fnc[1:0] + 2'h1; // R6
            2'h1: st_nxt.e_fnc[2] = ~st_r.e_fnc[2]; // R8
            2'h2: st_nxt.e_fnc[4:3] = st_r.e_fnc[4:3] + 2'h1; // R6
            default: st_nxt.e_fnc[5] = ~st_r.e_fnc[5]; // R8
          endcase
        end
        APC_PG_CNT: begin
          // Counts wrap 15 back to 1, never 0
          if (!st_r.cur[0]) begin
            st_nxt.e_cnt1 = (st_r.e_cnt1 >= APC_CNT_MAX) ? APC_CNT_MIN
              : st_r.e_cnt1 + 4'h1; // R14 R9
          end else begin
            st_nxt.e_cnt2 = (st_r.e_cnt2 >= APC_CNT_MAX) ? APC_CNT_MIN
              : st_r.e_cnt2 + 4'h1; // R14 R9
          end
        end
        APC_PG_SPHY, APC_PG_ALHY: begin
          if (st_r.shown) begin
            // Digit 0 is the leftmost BCD digit
            dg = st_r.e_hys[(3 - st_r.cur[1:0]) * 4 +: 4];
            st_nxt.e_hys[(3 - st_r.cur[1:0]) * 4 +: 4] =
              (dg >= APC_DIGIT_MAX) ? 4'h0 : dg + 4'h1; // R15 R10 R11
          end
        end
        default: st_nxt.cur = st_r.cur;
      endcase
    end
    // APB: access phase takes one wait state; deadbands and status are read-only
    if (psel && penable && !st_r.rdy) begin
      st_nxt.rdy = 1'b1;
      st_nxt.rdata = '0;
      case (paddr)
        APC_CFG_OFF: begin
          st_nxt.rdata = {24'h0000_00, st_r.cfg};
          if (pwrite) st_nxt.cfg = pwdata[7:0];
        end
        APC_FNC_OFF: begin
          st_nxt.rdata = {24'h0000_00, st_r.fnc};
          if (pwrite) st_nxt.fnc = {2'b00, pwdata[5:0]};
        end
        APC_CNT_OFF: begin
          st_nxt.rdata = {24'h0000_00, st_r.cnt2, st_r.cnt1};
          if (pwrite && pwdata[3:0] != 4'h0) st_nxt.cnt1 = pwdata[3:0];
          if (pwrite && pwdata[7:4] != 4'h0) st_nxt.cnt2 = pwdata[7:4];
        end
        APC_SPHY_OFF: st_nxt.rdata = {16'h0000, st_r.sphy};
        APC_ALHY_OFF: st_nxt.rdata = {16'h0000, st_r.alhy};
        APC_PT1_OFF: begin
          st_nxt.rdata = {16'h0000, st_r.pt1};
          if (pwrite) st_nxt.pt1 = pwdata[15:0];
        end
        APC_PT2_OFF: begin
          st_nxt.rdata = {16'h0000, st_r.pt2};
          if (pwrite) st_nxt.pt2 = pwdata[15:0];
        end
        APC_REF1_OFF: begin
          st_nxt.rdata = {16'h0000, st_r.ref1};
          if (pwrite) st_nxt.ref1 = pwdata[15:0];
        end
        APC_REF2_OFF: begin
          st_nxt.rdata = {16'h0000, st_r.ref2};
          if (pwrite) st_nxt.ref2 = pwdata[15:0];
        end
        APC_STAT_OFF: st_nxt.rdata = {24'h0000_00, 2'b00, st_r.pg,
          1'b0, act2, act1};
        default: st_nxt.err = 1'b1;
      endcase
    end
  end

  // Presets load at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.cfg <= APC_CFG_RST; // R16
      st_r.fnc <= APC_FNC_RST; // R16 R6
      st_r.e_cfg <= APC_CFG_RST;
      st_r.e_fnc <= APC_FNC_RST;
      st_r.cnt1 <= APC_CNT_RST; // R9
      st_r.cnt2 <= APC_CNT_RST;
      st_r.e_cnt1 <= APC_CNT_RST;
      st_r.e_cnt2 <= APC_CNT_RST;
      st_r.sphy <= APC_HYS_RST; // R10
      st_r.alhy <= APC_HYS_RST; // R11
      st_r.pg <= APC_PG_CFG;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = st_r.rdy;
  assign pslverr = st_r.err;
  assign alarm1_out = st_r.a1o;
  assign alarm2_out = st_r.a2o;
  assign alarm1_led = st_r.a1l;
  assign alarm2_led = st_r.a2l;
  assign page = st_r.pg;
  assign cursor = st_r.cur;
endmodule // apc_top
`default_nettype wire

// ---- sim/apc_properties.sv ----
// Port-level checks for the alarm point block
`timescale 1ns/1ps
`default_nettype none
module apc_properties
  import apc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic key_menu,
  input wire logic key_min,
  input wire logic key_max,
  input wire logic alarm1_out,
  input wire logic alarm2_out,
  input wire logic alarm1_led,
  input wire logic alarm2_led,
  input wire logic [2:0] page,
  input wire logic [2:0] cursor
);
  import apc_pkg::*;
  logic [7:0] cfg_r;
  logic [1:0] age_r;
  logic ok;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of APB config writes; keypad edits are not tracked, so only
  // bits that the keypad is never used to change are relied upon
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= APC_CFG_RST;
      age_r <= 2'h0;
    end else if (psel && penable && pready && pwrite &&
                 paddr == APC_CFG_OFF) begin
      cfg_r <= pwdata[7:0];
      age_r <= 2'h0;
    end else if (age_r != 2'h3) begin
      age_r <= age_r + 2'h1;
    end
  end
  // Give the config a few cycles to reach the outputs
  assign ok = age_r == 2'h3;
  AST_DIS_DARK: assert property (
    ok && cfg_r[6] |-> !alarm1_led && !alarm2_led)
    else $error("led lit while alarms disabled");
  AST_A1_ON: assert property (
    ok && alarm1_led && $past(alarm1_led) && $past(alarm1_led, 2)
    |-> alarm1_out == !cfg_r[1]) else $error("alarm1 out wrong when active");
  AST_A2_ON: assert property (
    ok && alarm2_led && $past(alarm2_led) && $past(alarm2_led, 2)
    |-> alarm2_out == !cfg_r[4]) else $error("alarm2 out wrong when active");
  AST_A1_IDLE: assert property (
    ok && !cfg_r[6] && !alarm1_led && !$past(alarm1_led) &&
    $stable(alarm1_out) |-> alarm1_out == cfg_r[1])
    else $error("alarm1 out wrong when idle");
  AST_RST_OUT: assert property (
    $rose(presetn) |-> page == 3'd0 && cursor == 3'd0 && !alarm1_led)
    else $error("outputs not at preset after reset");
  AST_PAGE_STEP: assert property (
    $changed(page) && $past(page) != 3'd5 |-> page == $past(page) + 3'd1)
    else $error("page skipped");
  AST_MENU_LAT: assert property (
    $rose(key_menu) && !key_min && !key_max && page != 3'd5
    |-> ##[1:4] $changed(page)) else $error("menu press not taken");
  AST_MIN_LAT: assert property (
    $rose(key_min) && !key_menu && !key_max && page == 3'd0
    |-> ##[1:4] $changed(cursor)) else $error("min press not taken");
  AST_CUR_STEP: assert property (
    $changed(cursor) && page == 3'd0 && $past(page) == 3'd0
    |-> cursor == $past(cursor) + 3'd1) else $error("cursor skipped");
endmodule // apc_properties
`default_nettype wire

// ---- sim/apc_keypad.sv ----
// Front-panel keypad model: one press of one button per request
`timescale 1ns/1ps
`default_nettype none
module apc_keypad (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] kp_key,
  input wire logic kp_go,
  output logic kp_done,
  output logic key_menu,
  output logic key_min,
  output logic key_max
);
  logic [3:0] t_r;
  // Hold past the synchroniser, then a gap so the next press is a new edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_r <= 4'h0;
      {key_menu, key_min, key_max} <= 3'b000;
    end else if (t_r != 4'h0) begin
      t_r <= t_r - 4'h1;
      if (t_r == 4'h6) begin
        {key_menu, key_min, key_max} <= 3'b000;
      end
    end else if (kp_go) begin
      t_r <= 4'hA;
      key_menu <= kp_key == 2'h0;
      key_min <= kp_key == 2'h1;
      key_max <= kp_key == 2'h2;
    end
  end
  assign kp_done = t_r == 4'h1;
endmodule // apc_keypad
`default_nettype wire

// ---- sim/apc_top_test.sv ----
// Self-checking bench for the alarm point block
`timescale 1ns/1ps
`default_nettype none
module apc_top_test;
  import apc_pkg::*;
  logic pclk = 1'b0;
  logic presetn;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, kp_done, key_menu, key_min, key_max;
  logic ext_alarm_reset = 1'b0, rdg_valid = 1'b0, kp_go = 1'b0;
  logic [15:0] rdg_raw = 16'h0000, rdg_filt = 16'h0000;
  logic alarm1_out, alarm2_out, alarm1_led, alarm2_led;
  logic [2:0] page, cursor;
  logic [1:0] kp_key = 2'h0;
  int miscompares = 0, n_tests = 0, cyc = 0;
  always #50 pclk = ~pclk;
  apc_top i_apc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .key_menu, .key_min, .key_max,
    .ext_alarm_reset, .rdg_raw, .rdg_filt, .rdg_valid, .alarm1_out,
    .alarm2_out, .alarm1_led, .alarm2_led, .page, .cursor);
  apc_keypad i_apc_keypad (.pclk, .presetn, .kp_key, .kp_go, .kp_done,
    .key_menu, .key_min, .key_max);
  // Verdict and end of run
  task automatic close_out;
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // One APB transfer; idle cycle after it so psel is never set twice at once
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    chk(pslverr === (a > APC_REF2_OFF), "slave error flag");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(q === x, "read data");
  endtask
  // Readings arrive as one-cycle valid pulses with a gap between them
  task automatic feed(input logic [15:0] r, input logic [15:0] f, int n);
    repeat (n) begin
      rdg_raw <= r;
      rdg_filt <= f;
      rdg_valid <= 1'b1;
      @(posedge pclk);
      rdg_valid <= 1'b0;
      @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic al(input logic l, input logic o, input string m);
    chk(alarm1_led === l && alarm1_out === o, m);
    chk(alarm2_led === l && alarm2_out === o, m);
  endtask
  task automatic press(input logic [1:0] k);
    kp_key <= k;
    kp_go <= 1'b1;
    @(posedge pclk);
    kp_go <= 1'b0;
    repeat (2) @(posedge pclk);
    while (kp_done !== 1'b1) @(posedge pclk);
    @(posedge pclk);
  endtask
  task automatic t_presets;
    rd(APC_CFG_OFF, 32'h0000_0000);
    rd(APC_FNC_OFF, 32'h0000_0000);
    rd(APC_CNT_OFF, 32'h0000_0033);
    rd(APC_SPHY_OFF, 32'h0000_0020);
    rd(APC_ALHY_OFF, 32'h0000_0020);
    rd(8'h28, 32'h0000_0000);
    rd(APC_STAT_OFF, 32'h0000_0000);
  endtask
  // Point 100, deadband 32: trips above 116, clears at 84 or below
  task automatic t_process;
    wr(APC_PT1_OFF, 32'h0000_0064);
    wr(APC_PT2_OFF, 32'h0000_0064);
    rd(APC_PT1_OFF, 32'h0000_0064);
    feed(16'd110, 16'd110, 3);
    al(1'b0, 1'b0, "tripped inside band");
    feed(16'd200, 16'd200, 2);
    feed(16'd50, 16'd50, 1);
    feed(16'd200, 16'd200, 2);
    al(1'b0, 1'b0, "tripped before count");
    feed(16'd200, 16'd200, 1);
    al(1'b1, 1'b1, "no trip above");
    feed(16'd90, 16'd90, 3);
    al(1'b1, 1'b1, "cleared inside band");
    feed(16'd80, 16'd80, 3);
    al(1'b0, 1'b0, "unlatched not cleared");
  endtask
  task automatic t_zone_pol;
    wr(APC_CFG_OFF, 32'h0000_001B);
    feed(16'd50, 16'd50, 3);
    al(1'b1, 1'b0, "below zone or off polarity");
    feed(16'd200, 16'd200, 3);
    al(1'b0, 1'b1, "idle output with off polarity");
    wr(APC_CFG_OFF, 32'h0000_0024);
    feed(16'd200, 16'd50, 3);
    al(1'b0, 1'b0, "raw reading compared");
    feed(16'd50, 16'd200, 3);
    al(1'b1, 1'b1, "filtered reading ignored");
    wr(APC_CFG_OFF, 32'h0000_0040);
    al(1'b0, 1'b0, "leds lit while disabled");
    wr(APC_CFG_OFF, 32'h0000_0000);
    feed(16'd50, 16'd50, 3);
  endtask
  task automatic ext_pulse;
    ext_alarm_reset <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_alarm_reset <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_latch;
    wr(APC_FNC_OFF, 32'h0000_0024);
    feed(16'd200, 16'd200, 3);
    feed(16'd50, 16'd50, 3);
    al(1'b1, 1'b1, "latched alarm cleared");
    ext_pulse();
    al(1'b1, 1'b1, "reset input not ignored");
    wr(APC_CFG_OFF, 32'h0000_0080);
    ext_pulse();
    al(1'b0, 1'b0, "reset input not honoured");
    wr(APC_CFG_OFF, 32'h0000_0000);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      wr(APC_FNC_OFF, 32'(m * 9));
      rd(APC_FNC_OFF, 32'(m * 9));
    end
    wr(APC_REF1_OFF, 32'h0000_03E8);
    wr(APC_FNC_OFF, 32'h0000_0001);
    feed(16'd1200, 16'd1200, 3);
    chk(alarm1_led === 1'b1, "high deviation not tripped");
    feed(16'd1050, 16'd1050, 3);
    chk(alarm1_led === 1'b0, "high deviation not cleared");
    // Low deviation looks at ref minus reading; band at the magnitude
    wr(APC_FNC_OFF, 32'h0000_0002);
    feed(16'd1150, 16'd1150, 3);
    chk(alarm1_led === 1'b0, "low deviation tripped high");
    feed(16'd850, 16'd850, 3);
    chk(alarm1_led === 1'b1, "low deviation not tripped");
    feed(16'd1000, 16'd1000, 3);
    chk(alarm1_led === 1'b0, "low deviation not cleared");
    wr(APC_FNC_OFF, 32'h0000_0003);
    feed(16'd1150, 16'd1150, 3);
    chk(alarm1_led === 1'b1, "band deviation not tripped");
    feed(16'd1000, 16'd1000, 3);
    chk(alarm1_led === 1'b0, "band deviation not cleared");
    wr(APC_FNC_OFF, 32'h0000_0000);
  endtask
  // Keys: 0 menu, 1 min, 2 max
  task automatic t_keys;
    repeat (7) press(2'h1);
    chk(cursor === 3'd7 && page === 3'd0, "cursor steps");
    press(2'h2);
    press(2'h0);
    chk(page === 3'd1, "menu advance");
    rd(APC_CFG_OFF, 32'h0000_0080);
    press(2'h0);
    press(2'h2);
    press(2'h1);
    press(2'h2);
    press(2'h0);
    chk(page === 3'd3, "count page");
    rd(APC_CNT_OFF, 32'h0000_0044);
    // Setpoint deadband: show, bump the leftmost digit, commit
    press(2'h1);
    press(2'h2);
    press(2'h0);
    // Alarm deadband: show, move to the second digit, bump it
    press(2'h1);
    press(2'h1);
    chk(cursor === 3'd1, "digit select");
    press(2'h2);
    press(2'h0);
    chk(page === 3'd5, "output page");
    rd(APC_SPHY_OFF, 32'h0000_1020);
    rd(APC_ALHY_OFF, 32'h0000_0120);
    wr(APC_CFG_OFF, 32'h0000_0000);
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_presets();
    t_process();
    t_zone_pol();
    t_latch();
    t_modes();
    t_keys();
    close_out();
  end
endmodule // apc_top_test
bind apc_top apc_properties i_apc_properties (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .key_menu, .key_min,
  .key_max, .alarm1_out, .alarm2_out, .alarm1_led, .alarm2_led, .page,
  .cursor);
`default_nettype wire
